// File: pxc_exec_ctrl.sv
// Execution control: operand checks, indirect pointer, edge detection, flags
// Notes on behaviour
// - Multi-word operand stays in one area
// - IO and system areas join when both allowed
// - Shared flags sit at fixed system bits
// - Failed execution sets the error flag
// - Bad operand specification sets the error flag
// - Error flag suppresses instruction execution
// - Indirect operand reads pointer, then target word
// - Pointer must be BCD within 0000..6655
// - Redirect selects extended memory bank instead
// - Constants checked as BCD or hex range
// - Level form executes every scan condition on
// - Edge form executes once on rising condition
// - Edge form skipped when steady or falling
// - Edge form selected by marker, same code
// - Rising pulse sets bit one scan
// - Falling pulse sets bit one scan
`timescale 1ns/1ps
module pxc_exec_ctrl
	import pxc_pkg::*;
#(
	parameter int INST_N = 64,
	parameter int IDX_W  = 6,
	parameter int BANK_W = 3
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              program_start,
	input  wire logic              instr_valid,
	input  wire logic [IDX_W-1:0]  instr_index,
	input  wire logic [7:0]        instr_code,
	input  wire logic              edge_marker,
	input  wire logic              exec_cond,
	input  wire logic              operand_bad,
	input  wire logic              exec_fail,
	input  wire logic [1:0]        operand_area,
	input  wire logic [13:0]       operand_addr,
	input  wire logic [2:0]        operand_words,
	input  wire logic              operand_io_sys_ok,
	input  wire logic              operand_indirect,
	input  wire logic [15:0]       pointer_word,
	input  wire logic              redirect_set,
	input  wire logic              redirect_clear,
	input  wire logic [BANK_W-1:0] redirect_bank,
	input  wire logic              const_present,
	input  wire logic [15:0]       const_value,
	input  wire logic              const_is_bcd,
	input  wire logic [15:0]       const_max,
	input  wire logic [7:0]        result_flags_in,
	input  wire logic              result_flags_we,
	output logic                   exec_go,
	output logic                   pulse_bit,
	output logic                   pulse_bit_we,
	output logic                   exec_error_flag,
	output logic                   carry_flag,
	output logic                   greater_flag,
	output logic                   equal_flag,
	output logic                   less_flag,
	output logic                   negative_flag,
	output logic                   overflow_flag,
	output logic                   underflow_flag,
	output logic [13:0]            target_addr,
	output logic                   target_in_ext,
	output logic [BANK_W-1:0]      target_bank,
	output logic [19:0]            error_flag_bit
);

	// Elaboration checks: every instance needs a history slot it can address
	if (INST_N < 1 || INST_N > (1 << IDX_W)) begin : g_bad_inst
		$error("INST_N does not fit the index width");
	end
	if (IDX_W < 1 || IDX_W > 16) begin : g_bad_idx
		$error("IDX_W out of range");
	end
	if (BANK_W < 1 || BANK_W > 8) begin : g_bad_bank
		$error("BANK_W out of range");
	end
	// Area bounds must sit in order or the span check would accept overlaps
	if (PXC_IO_LAST >= PXC_SYS_FIRST || PXC_SYS_FIRST > PXC_SYS_LAST) begin : g_bad_area
		$error("area bounds out of order");
	end
	if (PXC_PTR_MAX_BCD > 16'h9999) begin : g_bad_ptr
		$error("pointer limit is not four decimal digits");
	end

	// True when every digit is decimal
	function automatic logic is_bcd(input logic [15:0] v);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (v[i*4 +: 4] > 4'h9) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : is_bcd

	// Four BCD digits to a binary word address
	function automatic logic [13:0] bcd_to_bin(input logic [15:0] v);
		logic [13:0] r;
		r = 14'(v[15:12]) * 14'd1000 + 14'(v[11:8]) * 14'd100 + 14'(v[7:4]) * 14'd10 + 14'(v[3:0]);
		return r;
	endfunction : bcd_to_bin

	// Operand span check
	logic [14:0] last_addr;
	logic        span_ok;
	logic        io_sys_cross;
	assign last_addr    = {1'b0, operand_addr} + 15'(operand_words) - 15'h0001;
	assign io_sys_cross = (operand_area == PXC_AREA_IO) && operand_io_sys_ok
		&& (last_addr <= {1'b0, PXC_SYS_LAST});
	logic        words_ok;
	logic        io_fit;
	logic        sys_fit;
	logic        mem_fit;
	logic        area_fit;
	assign words_ok = (operand_words != 3'h0);
	assign io_fit   = (last_addr <= {1'b0, PXC_IO_LAST}) || io_sys_cross;
	assign sys_fit  = (last_addr <= {1'b0, PXC_SYS_LAST}) && (operand_addr >= PXC_SYS_FIRST);
	// Other areas only refuse a wrap past the top of the word space
	assign mem_fit  = (last_addr[14] == 1'b0);
	assign area_fit = (operand_area == PXC_AREA_IO)  ? io_fit :
		(operand_area == PXC_AREA_SYS) ? sys_fit : mem_fit;
	assign span_ok  = words_ok && area_fit;

	// Indirect pointer check, digit by digit
	logic [3:0] ptr_digit_ok;
	logic       ptr_ok;
	generate
		for (genvar d = 0; d < 4; d++) begin : g_ptr_digit
			assign ptr_digit_ok[d] = (pointer_word[d*4 +: 4] <= 4'h9);
		end
	endgenerate
	// A plain compare is only meaningful once every digit is decimal
	assign ptr_ok = (&ptr_digit_ok) && (pointer_word <= PXC_PTR_MAX_BCD);

	// Constant format check
	logic const_fmt_ok;
	logic const_range_ok;
	logic const_ok;
	assign const_fmt_ok   = !const_is_bcd || is_bcd(const_value);
	assign const_range_ok = (const_value <= const_max);
	assign const_ok       = !const_present || (const_fmt_ok && const_range_ok);

	logic spec_error;
	assign spec_error = operand_bad || !span_ok || (operand_indirect && !ptr_ok) || !const_ok;
	logic err_now;
	assign err_now = spec_error || exec_fail;

	// Edge history per instance
	logic [INST_N-1:0] prev_cond_reg;
	logic              prev_cond;
	assign prev_cond = prev_cond_reg[instr_index];

	logic is_rise_pulse;
	logic is_fall_pulse;
	logic edge_form;
	logic rising;
	logic falling;
	logic want_exec;
	assign is_rise_pulse = (instr_code == PXC_CODE_RISE);
	assign is_fall_pulse = (instr_code == PXC_CODE_FALL);
	assign edge_form     = edge_marker;
	assign rising        = exec_cond && !prev_cond;
	assign falling       = !exec_cond && prev_cond;
	assign want_exec     = edge_form ? rising : exec_cond;
	// Edge history is only tracked while the program runs
	pxc_state_t state_reg;
	pxc_state_t state_next;
	always_comb begin
		case (state_reg)
			PXC_ST_IDLE: begin
				state_next = program_start ? PXC_ST_RUN : PXC_ST_IDLE;
			end
			PXC_ST_RUN: begin
				state_next = PXC_ST_RUN;
			end
			default: begin
				state_next = PXC_ST_IDLE;
			end
		endcase
	end

	// History is only kept for instructions that look at edges
	logic hist_kind;
	logic run_state;
	logic track;
	assign hist_kind = edge_form || is_rise_pulse || is_fall_pulse;
	assign run_state = (state_reg == PXC_ST_RUN);
	assign track     = instr_valid && run_state && !program_start && hist_kind;

	generate
		for (genvar g = 0; g < INST_N; g++) begin : g_hist
			always_ff @(posedge core_clk) begin
				if (rst || program_start) begin
					prev_cond_reg[g] <= 1'b0;
				end else if (track && (instr_index == IDX_W'(g))) begin
					prev_cond_reg[g] <= exec_cond;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= PXC_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Redirect of indirect references
	logic              redir_reg;
	logic [BANK_W-1:0] redir_bank_reg;
	// Set wins over clear when both arrive together
	always_ff @(posedge core_clk) begin
		if (rst) begin
			redir_reg <= 1'b0;
		end else if (redirect_set) begin
			redir_reg <= 1'b1;
		end else if (redirect_clear) begin
			redir_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			redir_bank_reg <= '0;
		end else if (redirect_set) begin
			redir_bank_reg <= redirect_bank;
		end
	end

	logic [13:0] addr_next;
	assign addr_next = operand_indirect ? bcd_to_bin(pointer_word) : operand_addr;

	// Pulse instructions ignore the error path; everything else is gated by it
	logic go_next;
	logic pulse_we_next;
	logic pulse_next;
	logic normal_instr;
	logic err_flag_next;
	logic ext_next;
	logic flags_we;

	// Decode of the instruction kind
	assign normal_instr  = instr_valid && !is_rise_pulse && !is_fall_pulse;
	assign go_next       = normal_instr && want_exec && !err_now;
	assign pulse_we_next = instr_valid && (is_rise_pulse || is_fall_pulse);
	assign pulse_next    = pulse_we_next && (is_rise_pulse ? rising : falling);
	// Error only counts when the instruction wanted to run; a skipped edge form stays clean
	assign err_flag_next = err_now && want_exec;
	assign ext_next      = operand_indirect && redir_reg;
	// Flags only follow an instruction that really ran
	assign flags_we      = result_flags_we && go_next;

	// One-scan strobes, high for exactly one cycle after the instruction
	always_ff @(posedge core_clk) begin
		if (rst) begin
			exec_go <= 1'b0;
		end else begin
			exec_go <= go_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pulse_bit_we <= 1'b0;
		end else begin
			pulse_bit_we <= pulse_we_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pulse_bit <= 1'b0;
		end else begin
			pulse_bit <= pulse_next;
		end
	end

	// Error flag and target hold until the next normal instruction
	always_ff @(posedge core_clk) begin
		if (rst) begin
			exec_error_flag <= 1'b0;
		end else if (normal_instr) begin
			exec_error_flag <= err_flag_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			target_addr <= '0;
		end else if (normal_instr) begin
			target_addr <= addr_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			target_in_ext <= 1'b0;
		end else if (normal_instr) begin
			target_in_ext <= ext_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			target_bank <= '0;
		end else if (normal_instr) begin
			target_bank <= redir_bank_reg;
		end
	end

	// Arithmetic flags: bit order C,G,E,L,N,O,U; the spare top bit is ignored
	logic [6:0] flag_reg;
	generate
		for (genvar f = 0; f < 7; f++) begin : g_flag
			always_ff @(posedge core_clk) begin
				if (rst) begin
					flag_reg[f] <= PXC_FLAGS_RESET[f];
				end else if (flags_we) begin
					flag_reg[f] <= result_flags_in[f];
				end
			end
		end
	endgenerate
	assign {carry_flag, greater_flag, equal_flag, less_flag,
		negative_flag, overflow_flag, underflow_flag} = flag_reg;

	// Constant, but kept in a flip-flop so every output leaves from a register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			error_flag_bit <= PXC_BIT_ERROR;
		end else begin
			error_flag_bit <= PXC_BIT_ERROR;
		end
	end

endmodule : pxc_exec_ctrl

// File: pxc_pkg.sv
// Package with constants for the instruction execution control block
package pxc_pkg;
	localparam int          PXC_AREA_AW        = 14;
	localparam logic [13:0] PXC_IO_FIRST       = 14'h0000;
	localparam logic [13:0] PXC_IO_LAST        = 14'h00EB;
	localparam logic [13:0] PXC_SYS_FIRST      = 14'h00EC;
	localparam logic [13:0] PXC_SYS_LAST       = 14'h00FF;
	localparam logic [15:0] PXC_PTR_MAX_BCD    = 16'h6655;
	localparam logic [7:0]  PXC_CODE_RISE      = 8'h13;
	localparam logic [7:0]  PXC_CODE_FALL      = 8'h14;
	localparam logic [19:0] PXC_BIT_ERROR      = 20'h25503;
	localparam logic [19:0] PXC_BIT_CARRY      = 20'h25504;
	localparam logic [19:0] PXC_BIT_GREATER    = 20'h25505;
	localparam logic [19:0] PXC_BIT_EQUAL      = 20'h25506;
	localparam logic [19:0] PXC_BIT_LESS       = 20'h25507;
	localparam logic [19:0] PXC_BIT_NEGATIVE   = 20'h25402;
	localparam logic [19:0] PXC_BIT_OVERFLOW   = 20'h25404;
	localparam logic [19:0] PXC_BIT_UNDERFLOW  = 20'h25405;
	localparam logic [7:0]  PXC_FLAGS_RESET    = 8'h00;
	typedef enum logic [1:0] {
		PXC_AREA_IO   = 2'b00,
		PXC_AREA_SYS  = 2'b01,
		PXC_AREA_DATA = 2'b10,
		PXC_AREA_OTH  = 2'b11
	} pxc_area_t;
	typedef enum logic [1:0] {
		PXC_ST_IDLE   = 2'b00,
		PXC_ST_RUN    = 2'b01
	} pxc_state_t;
endpackage : pxc_pkg

// File: pxc_exec_checker.sv
// Port checker for the execution control block
`timescale 1ns/1ps
module pxc_exec_checker
	import pxc_pkg::*;
(
	input logic        core_clk,
	input logic        rst,
	input logic        instr_valid,
	input logic [7:0]  instr_code,
	input logic        edge_marker,
	input logic        exec_cond,
	input logic        operand_bad,
	input logic        exec_fail,
	input logic [1:0]  operand_area,
	input logic [13:0] operand_addr,
	input logic [2:0]  operand_words,
	input logic        operand_indirect,
	input logic [15:0] pointer_word,
	input logic        exec_go,
	input logic        pulse_bit_we,
	input logic        exec_error_flag,
	input logic [19:0] error_flag_bit
);
	logic np;
	// Level form wanted this scan; pulse codes never raise the error flag
	assign np = instr_valid && exec_cond && !edge_marker && instr_code != PXC_CODE_RISE && instr_code != PXC_CODE_FALL;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_bit; error_flag_bit == PXC_BIT_ERROR; endproperty
	a_bit: assert property (p_bit) else $error("error flag bit moved");
	property p_cause; exec_go |-> $past(instr_valid) && $past(exec_cond); endproperty
	a_cause: assert property (p_cause) else $error("go without cause");
	property p_sup; exec_go |-> !exec_error_flag; endproperty
	a_sup: assert property (p_sup) else $error("go with error");
	property p_bad; np && operand_bad |=> exec_error_flag && !exec_go; endproperty
	a_bad: assert property (p_bad) else $error("bad operand missed");
	property p_fail; np && exec_fail |=> exec_error_flag && !exec_go; endproperty
	a_fail: assert property (p_fail) else $error("failure missed");
	property p_ptr; np && operand_indirect && operand_area == PXC_AREA_DATA && pointer_word[15:12] > 4'h6 |=> exec_error_flag; endproperty
	a_ptr: assert property (p_ptr) else $error("pointer range missed");
	property p_span; np && operand_area == PXC_AREA_SYS && operand_addr == PXC_SYS_LAST && operand_words == 3'h2 |=> exec_error_flag; endproperty
	a_span: assert property (p_span) else $error("area span missed");
	property p_skip; instr_valid && edge_marker && !exec_cond |=> !exec_go; endproperty
	a_skip: assert property (p_skip) else $error("edge form ran");
	property p_pulse; pulse_bit_we |-> $past(instr_valid) && ($past(instr_code) == PXC_CODE_RISE || $past(instr_code) == PXC_CODE_FALL); endproperty
	a_pulse: assert property (p_pulse) else $error("stray pulse write");
endmodule : pxc_exec_checker
bind pxc_exec_ctrl pxc_exec_checker chk_u (.core_clk, .rst, .instr_valid, .instr_code, .edge_marker, .exec_cond,
	.operand_bad, .exec_fail, .operand_area, .operand_addr, .operand_words, .operand_indirect, .pointer_word,
	.exec_go, .pulse_bit_we, .exec_error_flag, .error_flag_bit);

// File: tb.sv
// Testbench for the execution control block
`timescale 1ns/1ps
module tb;
	import pxc_pkg::*;
	logic core_clk, rst, program_start, instr_valid, edge_marker, exec_cond, operand_bad, exec_fail, operand_io_sys_ok;
	logic operand_indirect, redirect_set, redirect_clear, const_present, const_is_bcd, result_flags_we, exec_go;
	logic pulse_bit, pulse_bit_we, exec_error_flag, carry_flag, greater_flag, equal_flag, less_flag, negative_flag;
	logic overflow_flag, underflow_flag, target_in_ext;
	logic [5:0]  instr_index;
	logic [7:0]  instr_code, result_flags_in;
	logic [1:0]  operand_area;
	logic [13:0] operand_addr, target_addr;
	logic [2:0]  operand_words, redirect_bank, target_bank;
	logic [15:0] pointer_word, const_value, const_max;
	logic [19:0] error_flag_bit;
	int fail_count = 0;
	int check_count = 0;
	pxc_exec_ctrl dut_u (.core_clk, .rst, .program_start, .instr_valid, .instr_index, .instr_code, .edge_marker,
		.exec_cond, .operand_bad, .exec_fail, .operand_area, .operand_addr, .operand_words, .operand_io_sys_ok,
		.operand_indirect, .pointer_word, .redirect_set, .redirect_clear, .redirect_bank, .const_present,
		.const_value, .const_is_bcd, .const_max, .result_flags_in, .result_flags_we, .exec_go, .pulse_bit,
		.pulse_bit_we, .exec_error_flag, .carry_flag, .greater_flag, .equal_flag, .less_flag, .negative_flag,
		.overflow_flag, .underflow_flag, .target_addr, .target_in_ext, .target_bank, .error_flag_bit);
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic clr;
		{program_start, instr_valid, edge_marker, exec_cond, operand_bad, exec_fail, operand_io_sys_ok} <= '0;
		{operand_indirect, redirect_set, redirect_clear, const_present, const_is_bcd, result_flags_we} <= '0;
		{instr_index, instr_code, result_flags_in, redirect_bank, pointer_word, const_value, operand_addr} <= '0;
		operand_area <= PXC_AREA_IO;
		operand_words <= 3'h1;
		const_max <= 16'hFFFF;
	endtask : clr
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic go(input logic [5:0] i, input logic [7:0] c, input logic e, input logic x);
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr_index <= i;
		instr_code <= c;
		edge_marker <= e;
		exec_cond <= x;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
	endtask : go
	// One instance replayed over four scans, conditions taken from the top bit down
	task automatic seq(input logic [5:0] i, input logic [7:0] c, input logic e, input logic [3:0] cs, ex, input bit p);
		for (int k = 3; k >= 0; k--) begin
			go(i, c, e, cs[k]);
			chk(p ? pulse_bit : exec_go, ex[k]);
			if (p) begin
				chk(pulse_bit_we, 1'b1);
			end
		end
	endtask : seq
	task automatic er(input logic [1:0] x);
		go(6'h04, 8'h21, 1'b0, 1'b1);
		chk({exec_error_flag, exec_go}, x);
	endtask : er
	task automatic t_level;
		result_flags_in <= 8'h41;
		result_flags_we <= 1'b1;
		seq(6'h00, 8'h21, 1'b0, 4'hE, 4'hE, 0);
		chk({carry_flag, greater_flag, equal_flag, less_flag, negative_flag, overflow_flag, underflow_flag}, 7'h41);
		$display("level test done");
	endtask : t_level
	task automatic t_edge;
		result_flags_we <= 1'b0;
		seq(6'h01, 8'h21, 1'b1, 4'hB, 4'hA, 0);
		seq(6'h02, PXC_CODE_RISE, 1'b0, 4'hD, 4'h9, 1);
		seq(6'h03, PXC_CODE_FALL, 1'b0, 4'h9, 4'h4, 1);
		$display("edge test done");
	endtask : t_edge
	task automatic t_err;
		operand_bad <= 1'b1;
		er(2'h2);
		operand_bad <= 1'b0;
		exec_fail <= 1'b1;
		er(2'h2);
		{exec_fail, operand_indirect, pointer_word, operand_area} <= {2'h1, 16'h7000, PXC_AREA_DATA};
		er(2'h2);
		{pointer_word, redirect_set, redirect_bank} <= {16'h1234, 1'b1, 3'h5};
		er(2'h1);
		chk({target_in_ext, target_bank}, 4'hD);
		chk(target_addr, 14'h04D2);
		{redirect_set, redirect_clear} <= 2'h1;
		er(2'h1);
		chk(target_in_ext, 1'b0);
		clr();
		{const_present, const_is_bcd, const_value, const_max} <= {2'h3, 16'h00A0, 16'h9999};
		er(2'h2);
		{const_is_bcd, const_max} <= {1'b0, 16'h00FF};
		er(2'h1);
		$display("error test done");
	endtask : t_err
	task automatic t_area;
		clr();
		{operand_area, operand_addr, operand_words} <= {PXC_AREA_SYS, PXC_SYS_LAST, 3'h2};
		er(2'h2);
		{operand_area, operand_addr, operand_io_sys_ok} <= {PXC_AREA_IO, PXC_IO_LAST, 1'b1};
		er(2'h1);
		operand_io_sys_ok <= 1'b0;
		er(2'h2);
		$display("area test done");
	endtask : t_area
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	// Whole run is well under a microsecond, so this only trips on a hang
	initial begin
		#20000;
		fail_count++;
		results();
	end
	initial begin
		rst <= 1'b1;
		clr();
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		chk({error_flag_bit, exec_go, exec_error_flag}, {PXC_BIT_ERROR, 2'h0});
		@(posedge core_clk);
		program_start <= 1'b1;
		@(posedge core_clk);
		program_start <= 1'b0;
		t_level();
		t_edge();
		t_err();
		t_area();
		results();
	end
endmodule : tb
